// ---- design/hpc_pkg.sv ----
// Shared types and constants for the downstream slot hot-plug controller
package hpc_pkg;

   // Slots exist for downstream ports 1, 6 and 7, held at indices 0, 1 and 2
   localparam int unsigned N_SLOTS = 3;

   // Sensor inputs of one slot, as seen on the expander
   typedef struct packed {
      logic attn_button;
      logic presence;
      logic power_fault;
      logic latch_sensor;
      logic power_good;
   } hpc_slot_in_t;

   // Indicator and control outputs of one slot
   typedef struct packed {
      logic attn_indicator;
      logic power_indicator;
      logic power_enable;
      logic interlock;
      logic slot_reset;
   } hpc_slot_out_t;

   typedef hpc_slot_in_t [N_SLOTS-1:0] hpc_slot_in_vec_t;
   typedef hpc_slot_out_t [N_SLOTS-1:0] hpc_slot_out_vec_t;

   // Avalon-MM slave request and answer
   typedef struct packed {
      logic read;
      logic write;
      logic [7:0] address;
      logic [3:0] byteenable;
      logic [31:0] writedata;
   } hpc_avm_req_t;

   typedef struct packed {
      logic waitrequest;
      logic [31:0] readdata;
   } hpc_avm_rsp_t;

   // Serial EEPROM initialisation write
   typedef struct packed {
      logic valid;
      logic [7:0] address;
      logic [31:0] data;
   } hpc_ee_wr_t;

   // Register byte addresses
   localparam logic [7:0] ADDR_HOTPLUG_CONFIG_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h04;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h08;
   localparam logic [7:0] ADDR_SLOT_BASE = 8'h10;
   localparam logic [7:0] ADDR_SLOT_STRIDE = 8'h10;
   localparam logic [7:0] OFS_SLOT_CAPABILITIES = 8'h00;
   localparam logic [7:0] OFS_SLOT_CONTROL = 8'h04;
   localparam logic [7:0] OFS_SLOT_STATUS = 8'h08;

   // Polarity invert and mode bit positions in hotplug_config_control
   localparam int unsigned INV_ATTN_BUTTON = 0;
   localparam int unsigned INV_PRESENCE = 1;
   localparam int unsigned INV_POWER_FAULT = 2;
   localparam int unsigned INV_LATCH_SENSOR = 3;
   localparam int unsigned INV_POWER_GOOD = 4;
   localparam int unsigned INV_ATTN_INDICATOR = 5;
   localparam int unsigned INV_POWER_INDICATOR = 6;
   localparam int unsigned INV_POWER_ENABLE = 7;
   localparam int unsigned INV_INTERLOCK = 8;
   localparam int unsigned INV_SLOT_RESET = 9;
   localparam int unsigned CFG_INTERLOCK_TOGGLE_MODE = 16;
   localparam int unsigned CFG_LATCH_SUBSTITUTION = 17;
   localparam int unsigned CFG_AUTO_POWER_OFF_ON_OPEN = 18;
   localparam logic [31:0] CFG_MASK = 32'h0007_03FF;
   localparam logic [31:0] CFG_RESET = 32'h0000_0000;

   // slot_capabilities fields
   localparam int unsigned CAP_LATCH_PRESENT = 2;
   localparam int unsigned CAP_CONTROLLER_PRESENT = 6;
   localparam logic [31:0] CAP_RESET = 32'h0000_0000;

   // slot_control fields
   localparam int unsigned CTL_ATTN_IND_LSB = 6;
   localparam int unsigned CTL_POWER_IND_LSB = 8;
   localparam int unsigned CTL_POWER_CONTROLLER_CONTROL = 10;
   localparam int unsigned CTL_INTERLOCK_CONTROL = 11;
   localparam logic [31:0] CTL_MASK = 32'h0000_07FF;
   localparam logic [31:0] CTL_RESET = 32'h0000_07C0;
   localparam logic [1:0] IND_ON = 2'h1;
   localparam logic [1:0] IND_BLINK = 2'h2;

   // slot_status fields; bits 0 to 4 are sticky events
   localparam int unsigned STS_ATTN_PRESSED = 0;
   localparam int unsigned STS_POWER_FAULT = 1;
   localparam int unsigned STS_LATCH_CHANGED = 2;
   localparam int unsigned STS_PRESENCE_CHANGED = 3;
   localparam int unsigned STS_COMMAND_COMPLETED = 4;
   localparam int unsigned STS_LATCH_SENSOR_STATE = 5;
   localparam int unsigned STS_PRESENCE_STATE = 6;
   localparam int unsigned STS_INTERLOCK_STATE = 7;
   localparam int unsigned STS_EVENT_BITS = 5;

   // Interlock pulse window
   localparam int unsigned CLK_MHZ = 250;
   localparam int unsigned ILOCK_MIN_MS = 100;
   localparam int unsigned ILOCK_MAX_MS = 150;
   localparam int unsigned ILOCK_MIN_CYCLES = ILOCK_MIN_MS * 1000 * CLK_MHZ + 1;
   localparam int unsigned ILOCK_MAX_CYCLES = ILOCK_MAX_MS * 1000 * CLK_MHZ - 1;
   localparam int unsigned ILOCK_PULSE_CYCLES = (ILOCK_MIN_CYCLES + ILOCK_MAX_CYCLES) / 2;

endpackage : hpc_pkg

// ---- design/hpc_slot_ctrl.sv ----
// Slot hot-plug controller for downstream ports 1, 6 and 7
//
// What this block does
// R1: Slot logic active only with controller present bit
// R2: Controllers only for ports 1, 6, 7
// R3: Slot signals exchanged through SMBus I/O expander
// R4: Five sensor inputs, five control outputs per slot
// R5: Slot reset on GPIO pin, not expander
// R6: Presence only from presence-detect pin
// R7: Indicators driven by port logic, wherever mounted
// R8: No in-band indicator or button messages
// R9: Per-signal polarity invert, common to all ports
// R10: Interlock write pulses output 100 to 150 ms
// R11: Toggle mode inverts interlock on each write
// R12: Latch substitution reports latch as interlock state
// R13: Substitution forces latch sensor state closed
// R14: Otherwise interlock state reads driven expander level
// R15: Auto power-off on open latch overrides power control
// R16: EEPROM may override hot-plug register defaults
// R17: Expander init after EEPROM; no completion flag
// R18: Interlock pulse timed by core-clock counter
`timescale 1ns/100ps
module hpc_slot_ctrl #(
   parameter logic [31:0] P_ILOCK_CYCLES = 32'(hpc_pkg::ILOCK_PULSE_CYCLES)
) (
   // Clock, reset, enable
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   input wire logic i_clk_en,
   // Avalon-MM register slave
   input wire hpc_pkg::hpc_avm_req_t i_avm,
   output hpc_pkg::hpc_avm_rsp_t o_avm,
   // Serial EEPROM initialisation
   input wire hpc_pkg::hpc_ee_wr_t i_ee_wr,
   input wire logic i_ee_done,
   // I/O expander side
   input wire hpc_pkg::hpc_slot_in_vec_t i_slot_in,
   output hpc_pkg::hpc_slot_out_vec_t o_slot_out,
   output logic o_exp_init,
   output logic o_exp_update,
   input wire logic i_exp_done,
   // GPIO alternate function and interrupt
   output logic [hpc_pkg::N_SLOTS-1:0] o_slot_reset_out,
   output logic o_irq
);
   import hpc_pkg::*;

   typedef struct packed {
      hpc_slot_in_vec_t ff1;
      hpc_slot_in_vec_t ff2;
      hpc_slot_in_vec_t ff3;
      hpc_slot_in_vec_t stable;
      logic [31:0] cfg;
      logic [N_SLOTS-1:0][31:0] cap;
      logic [N_SLOTS-1:0][31:0] ctl;
      logic [N_SLOTS-1:0][STS_EVENT_BITS-1:0] ev;
      logic [N_SLOTS-1:0] ilock;
      logic [N_SLOTS-1:0][31:0] ilock_cnt;
      logic [N_SLOTS-1:0] cmd_pend;
      logic [N_SLOTS-1:0] irq_sts;
      logic [N_SLOTS-1:0] irq_msk;
      hpc_slot_out_vec_t outs;
      logic ack;
      logic [31:0] rdata;
      logic init_done;
      logic exp_init;
      logic exp_update;
   } hpc_state_t;

   hpc_state_t s_reg;
   hpc_state_t s_next;

   localparam hpc_state_t STATE_RESET = '{
      cfg: CFG_RESET,
      cap: {N_SLOTS{CAP_RESET}},
      ctl: {N_SLOTS{CTL_RESET}},
      default: '0
   };

   function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] be);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return r;
   endfunction : be_merge

   function automatic logic [7:0] slot_addr(input int unsigned k, input logic [7:0] ofs);
      return 8'(ADDR_SLOT_BASE + 8'(k) * ADDR_SLOT_STRIDE + ofs);
   endfunction : slot_addr

   // Input polarity in the field order of hpc_slot_in_t
   function automatic hpc_slot_in_t in_inv(input logic [31:0] cfg);
      hpc_slot_in_t v;
      v.attn_button = cfg[INV_ATTN_BUTTON];
      v.presence = cfg[INV_PRESENCE];
      v.power_fault = cfg[INV_POWER_FAULT];
      v.latch_sensor = cfg[INV_LATCH_SENSOR];
      v.power_good = cfg[INV_POWER_GOOD];
      return v;
   endfunction : in_inv

   function automatic hpc_slot_out_t out_inv(input logic [31:0] cfg);
      hpc_slot_out_t v;
      v.attn_indicator = cfg[INV_ATTN_INDICATOR];
      v.power_indicator = cfg[INV_POWER_INDICATOR];
      v.power_enable = cfg[INV_POWER_ENABLE];
      v.interlock = cfg[INV_INTERLOCK];
      v.slot_reset = cfg[INV_SLOT_RESET];
      return v;
   endfunction : out_inv

   // Read mux
   function automatic logic [31:0] read_reg(input hpc_state_t st, input logic [7:0] a);
      logic [31:0] r;
      hpc_slot_in_t lv;
      logic ilock_st;
      logic latch_st;
      r = '0;
      if (a == ADDR_HOTPLUG_CONFIG_CONTROL) begin
         r = st.cfg;
      end
      if (a == ADDR_IRQ_STATUS) begin
         r[N_SLOTS-1:0] = st.irq_sts;
      end
      if (a == ADDR_IRQ_MASK) begin
         r[N_SLOTS-1:0] = st.irq_msk;
      end
      for (int unsigned k = 0; k < N_SLOTS; k++) begin
         lv = st.stable[k] ^ in_inv(st.cfg);
         if (st.cfg[CFG_LATCH_SUBSTITUTION]) begin
            ilock_st = lv.latch_sensor; // R12
            latch_st = 1'b0; // R13
         end else begin
            ilock_st = st.outs[k].interlock; // R14
            latch_st = lv.latch_sensor;
         end
         if (a == slot_addr(k, OFS_SLOT_CAPABILITIES)) begin
            r = st.cap[k];
         end
         if (a == slot_addr(k, OFS_SLOT_CONTROL)) begin
            r = st.ctl[k];
         end
         if (a == slot_addr(k, OFS_SLOT_STATUS)) begin
            r[STS_EVENT_BITS-1:0] = st.ev[k];
            r[STS_LATCH_SENSOR_STATE] = latch_st;
            r[STS_PRESENCE_STATE] = lv.presence; // R6
            r[STS_INTERLOCK_STATE] = ilock_st;
         end
      end
      return r;
   endfunction : read_reg

   always_comb begin
      logic [N_SLOTS-1:0][STS_EVENT_BITS-1:0] ev_set;
      hpc_slot_in_t cur_l;
      hpc_slot_in_t new_l;
      logic wen;
      logic from_ee;
      logic [7:0] wa;
      logic [31:0] wd;
      logic [3:0] wbe;
      logic en;
      logic auto_off;
      logic pwr_on;
      hpc_slot_out_t lo;
      ev_set = '0;
      cur_l = '0;
      new_l = '0;
      wen = 1'b0;
      from_ee = 1'b0;
      wa = '0;
      wd = '0;
      wbe = '0;
      en = 1'b0;
      auto_off = 1'b0;
      pwr_on = 1'b0;
      lo = '0;
      s_next = s_reg;
      s_next.exp_init = 1'b0;
      s_next.exp_update = 1'b0;

      // Three-stage synchroniser for expander inputs
      s_next.ff1 = i_slot_in;
      s_next.ff2 = s_reg.ff1;
      s_next.ff3 = s_reg.ff2;

      for (int unsigned k = 0; k < N_SLOTS; k++) begin
         en = s_reg.cap[k][CAP_CONTROLLER_PRESENT];
         cur_l = s_reg.stable[k] ^ in_inv(s_reg.cfg); // R9
         // Change accepted once stages two and three agree
         if (s_reg.ff2[k] == s_reg.ff3[k] && s_reg.ff3[k] != s_reg.stable[k]) begin
            s_next.stable[k] = s_reg.ff3[k];
            new_l = s_reg.ff3[k] ^ in_inv(s_reg.cfg);
            if (en) begin // R1
               ev_set[k][STS_ATTN_PRESSED] = new_l.attn_button & ~cur_l.attn_button;
               ev_set[k][STS_POWER_FAULT] = new_l.power_fault & ~cur_l.power_fault;
               ev_set[k][STS_LATCH_CHANGED] = new_l.latch_sensor ^ cur_l.latch_sensor;
               ev_set[k][STS_PRESENCE_CHANGED] = new_l.presence ^ cur_l.presence; // R6
            end
         end
         // Interlock pulse countdown
         if (s_reg.ilock_cnt[k] != '0) begin // R18
            s_next.ilock_cnt[k] = s_reg.ilock_cnt[k] - 32'h0000_0001;
            if (s_reg.ilock_cnt[k] == 32'h0000_0001) begin
               s_next.ilock[k] = 1'b0; // R10
            end
         end
         // Expander finished the update that a command asked for
         if (i_exp_done && s_reg.cmd_pend[k]) begin
            s_next.cmd_pend[k] = 1'b0;
            ev_set[k][STS_COMMAND_COMPLETED] = 1'b1;
         end
      end

      // Expander is set up only once EEPROM loading is over
      if (i_ee_done && !s_reg.init_done) begin // R17
         s_next.init_done = 1'b1;
         s_next.exp_init = 1'b1;
      end

      // Bus answer: one wait cycle, then the request completes
      s_next.ack = 1'b0;
      if ((i_avm.read || i_avm.write) && !s_reg.ack) begin
         s_next.ack = 1'b1;
         if (i_avm.read) begin
            s_next.rdata = read_reg(s_reg, i_avm.address);
         end
      end

      // EEPROM write first, bus write second so the bus wins a collision
      for (int src = 0; src < 2; src++) begin
         if (src == 0) begin
            wen = i_ee_wr.valid;
            from_ee = 1'b1;
            wa = i_ee_wr.address;
            wd = i_ee_wr.data;
            wbe = 4'hF;
         end else begin
            wen = i_avm.write && s_reg.ack;
            from_ee = 1'b0;
            wa = i_avm.address;
            wd = i_avm.writedata;
            wbe = i_avm.byteenable;
         end
         if (wen) begin
            if (wa == ADDR_HOTPLUG_CONFIG_CONTROL) begin
               s_next.cfg = be_merge(s_next.cfg, wd, wbe) & CFG_MASK; // R16
            end
            if (wa == ADDR_IRQ_STATUS && !from_ee && wbe[0]) begin
               s_next.irq_sts = s_next.irq_sts & ~wd[N_SLOTS-1:0];
            end
            if (wa == ADDR_IRQ_MASK && wbe[0]) begin
               s_next.irq_msk = wd[N_SLOTS-1:0];
            end
            for (int unsigned k = 0; k < N_SLOTS; k++) begin
               en = s_reg.cap[k][CAP_CONTROLLER_PRESENT];
               // Capabilities are set up by EEPROM only
               if (wa == slot_addr(k, OFS_SLOT_CAPABILITIES) && from_ee) begin
                  s_next.cap[k] = wd; // R16
               end
               if (wa == slot_addr(k, OFS_SLOT_CONTROL)) begin
                  s_next.ctl[k] = be_merge(s_next.ctl[k], wd, wbe) & CTL_MASK; // R16
                  if (!from_ee && en) begin // R17
                     s_next.cmd_pend[k] = 1'b1;
                     s_next.exp_update = 1'b1;
                     if (wd[CTL_INTERLOCK_CONTROL] && wbe[CTL_INTERLOCK_CONTROL / 8]) begin
                        if (s_reg.cfg[CFG_INTERLOCK_TOGGLE_MODE]) begin
                           s_next.ilock[k] = ~s_reg.ilock[k]; // R11
                           s_next.ilock_cnt[k] = '0;
                        end else begin
                           s_next.ilock[k] = 1'b1; // R10
                           s_next.ilock_cnt[k] = P_ILOCK_CYCLES; // R18
                        end
                     end
                  end
               end
               if (wa == slot_addr(k, OFS_SLOT_STATUS) && !from_ee && wbe[0]) begin
                  s_next.ev[k] = s_next.ev[k] & ~wd[STS_EVENT_BITS-1:0];
               end
            end
         end
      end

      // Sets land after clears so a same-cycle event survives
      for (int unsigned k = 0; k < N_SLOTS; k++) begin
         s_next.ev[k] = s_next.ev[k] | ev_set[k];
         if (ev_set[k] != '0) begin
            s_next.irq_sts[k] = 1'b1;
         end
      end

      // Slot outputs, wired locally through the expander except slot reset
      for (int unsigned k = 0; k < N_SLOTS; k++) begin // R2
         en = s_reg.cap[k][CAP_CONTROLLER_PRESENT];
         cur_l = s_reg.stable[k] ^ in_inv(s_reg.cfg);
         auto_off = s_reg.cfg[CFG_AUTO_POWER_OFF_ON_OPEN] && s_reg.cap[k][CAP_LATCH_PRESENT]
                    && cur_l.latch_sensor; // R15
         pwr_on = en && !s_reg.ctl[k][CTL_POWER_CONTROLLER_CONTROL] && !auto_off; // R15
         lo.attn_indicator = en && (s_reg.ctl[k][CTL_ATTN_IND_LSB +: 2] == IND_ON
                             || s_reg.ctl[k][CTL_ATTN_IND_LSB +: 2] == IND_BLINK); // R7
         lo.power_indicator = en && (s_reg.ctl[k][CTL_POWER_IND_LSB +: 2] == IND_ON
                              || s_reg.ctl[k][CTL_POWER_IND_LSB +: 2] == IND_BLINK); // R7
         lo.power_enable = pwr_on;
         lo.interlock = en && s_reg.ilock[k];
         // Slot held in reset until its power is on and good
         lo.slot_reset = en && !(pwr_on && cur_l.power_good);
         s_next.outs[k] = lo ^ out_inv(s_reg.cfg); // R8 R9
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         s_reg <= STATE_RESET;
      end else if (i_clk_en) begin
         s_reg <= s_next;
      end
   end

   // Answer only at an edge that really commits the access
   assign o_avm.waitrequest = (i_avm.read || i_avm.write) && !(s_reg.ack && i_clk_en);
   assign o_avm.readdata = s_reg.rdata;

   // Reset leaves the expander path and goes to its own pin
   always_comb begin
      o_slot_out = s_reg.outs; // R3 R4
      for (int unsigned k = 0; k < N_SLOTS; k++) begin
         o_slot_out[k].slot_reset = 1'b0; // R5
         o_slot_reset_out[k] = s_reg.outs[k].slot_reset; // R5
      end
   end

   assign o_exp_init = s_reg.exp_init; // R17
   assign o_exp_update = s_reg.exp_update; // R3
   assign o_irq = |(s_reg.irq_sts & s_reg.irq_msk);

endmodule : hpc_slot_ctrl

// ---- verif/hpc_exp_model.sv ----
// Behavioural model of the SMBus I/O expanders on the slot side
`timescale 1ns/100ps
module hpc_exp_model (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   // Controller side
   input wire logic i_update,
   output logic o_done,
   output hpc_pkg::hpc_slot_in_vec_t o_slot_in,
   // Bench control: pin levels and answer speed
   input wire hpc_pkg::hpc_slot_in_vec_t i_sense,
   input wire logic i_slow
);
   import hpc_pkg::*;
   logic [7:0] busy_reg;
   // An update is a whole bus transaction, so done may come late
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         busy_reg <= '0;
         o_slot_in <= '0;
      end else begin
         busy_reg <= {busy_reg[6:0], i_update};
         o_slot_in <= i_sense;
      end
   end
   assign o_done = i_slow ? busy_reg[7] : busy_reg[0];
endmodule : hpc_exp_model

// ---- verif/hpc_slot_ctrl_sva.sv ----
// Port-level assertions for the slot hot-plug controller
`timescale 1ns/100ps
module hpc_slot_ctrl_sva #(
   parameter logic [31:0] P_ILOCK_CYCLES = 32'(hpc_pkg::ILOCK_PULSE_CYCLES)
) (
   // Clock, reset, enable
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   input wire logic i_clk_en,
   // Register bus and EEPROM
   input wire hpc_pkg::hpc_avm_req_t i_avm,
   input wire hpc_pkg::hpc_avm_rsp_t o_avm,
   input wire hpc_pkg::hpc_ee_wr_t i_ee_wr,
   input wire logic i_ee_done,
   // Expander and pins
   input wire hpc_pkg::hpc_slot_in_vec_t i_slot_in,
   input wire hpc_pkg::hpc_slot_out_vec_t o_slot_out,
   input wire logic o_exp_init,
   input wire logic o_exp_update,
   input wire logic i_exp_done,
   input wire logic [hpc_pkg::N_SLOTS-1:0] o_slot_reset_out,
   input wire logic o_irq
);
   import hpc_pkg::*;
   logic wr_commit;
   logic ilock_wr;
   logic [31:0] cfg_reg;
   logic [31:0] cap_reg;
   logic [31:0] hi_cnt;
   logic [3:0] open_cnt;
   assign wr_commit = i_avm.write && !o_avm.waitrequest;
   assign ilock_wr = wr_commit && i_avm.address == ADDR_SLOT_BASE + OFS_SLOT_CONTROL
      && i_avm.writedata[CTL_INTERLOCK_CONTROL] && cap_reg[CAP_CONTROLLER_PRESENT];
   // Shadow of config, snooped from both writers, and of slot 0 capability, snooped from EEPROM
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         cfg_reg <= CFG_RESET;
         cap_reg <= CAP_RESET;
         hi_cnt <= '0;
         open_cnt <= '0;
      end else if (i_clk_en) begin
         if (wr_commit && i_avm.address == ADDR_HOTPLUG_CONFIG_CONTROL)
            cfg_reg <= i_avm.writedata & CFG_MASK;
         else if (i_ee_wr.valid && i_ee_wr.address == ADDR_HOTPLUG_CONFIG_CONTROL)
            cfg_reg <= i_ee_wr.data & CFG_MASK;
         if (i_ee_wr.valid && i_ee_wr.address == ADDR_SLOT_BASE)
            cap_reg <= i_ee_wr.data;
         hi_cnt <= o_slot_out[0].interlock ? hi_cnt + 1 : '0;
         if (!(i_slot_in[0].latch_sensor ^ cfg_reg[INV_LATCH_SENSOR]))
            open_cnt <= '0;
         else if (open_cnt != 4'hF)
            open_cnt <= open_cnt + 4'h1;
      end
   end
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rstn);
   gpio_reset_only_a: assert property (
      !(o_slot_out[0].slot_reset | o_slot_out[1].slot_reset | o_slot_out[2].slot_reset))
      else $error("slot reset seen on expander output");
   ee_no_update_a: assert property (
      i_ee_wr.valid && !wr_commit |=> !o_exp_update)
      else $error("EEPROM write started an expander update");
   update_cause_a: assert property (
      o_exp_update |-> $past(wr_commit) && $past(i_avm.address[3:0]) == 4'h4)
      else $error("expander update without slot control write");
   init_after_ee_a: assert property (
      o_exp_init |-> $past(i_ee_done))
      else $error("expander init before EEPROM load done");
   pulse_len_a: assert property (
      $fell(o_slot_out[0].interlock) && !cfg_reg[CFG_INTERLOCK_TOGGLE_MODE]
      && !cfg_reg[INV_INTERLOCK] |-> hi_cnt == P_ILOCK_CYCLES)
      else $error("interlock pulse length wrong");
   pulse_start_a: assert property (
      ilock_wr && !cfg_reg[CFG_INTERLOCK_TOGGLE_MODE] && !cfg_reg[INV_INTERLOCK]
      && !o_slot_out[0].interlock |-> ##[1:2] o_slot_out[0].interlock)
      else $error("interlock pulse did not start");
   ilock_toggle_a: assert property (
      ilock_wr && cfg_reg[CFG_INTERLOCK_TOGGLE_MODE]
      |-> ##[1:3] $changed(o_slot_out[0].interlock))
      else $error("interlock did not toggle");
   auto_off_a: assert property (
      open_cnt == 4'hA && cfg_reg[CFG_AUTO_POWER_OFF_ON_OPEN] && cap_reg[CAP_LATCH_PRESENT]
      && cap_reg[CAP_CONTROLLER_PRESENT] && !cfg_reg[INV_POWER_ENABLE]
      |-> !o_slot_out[0].power_enable)
      else $error("slot power kept with latch open");
   pulse_c: cover property ($fell(o_slot_out[0].interlock));
   init_c: cover property (o_exp_init);
   irq_c: cover property (o_irq);
endmodule : hpc_slot_ctrl_sva

bind hpc_slot_ctrl hpc_slot_ctrl_sva #(.P_ILOCK_CYCLES(P_ILOCK_CYCLES)) u_sva (
   .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_clk_en(i_clk_en), .i_avm(i_avm), .o_avm(o_avm),
   .i_ee_wr(i_ee_wr), .i_ee_done(i_ee_done), .i_slot_in(i_slot_in), .o_slot_out(o_slot_out),
   .o_exp_init(o_exp_init), .o_exp_update(o_exp_update), .i_exp_done(i_exp_done),
   .o_slot_reset_out(o_slot_reset_out), .o_irq(o_irq));

// ---- verif/test_downstream_slot_hotplug_control.sv ----
// Self-checking bench for the downstream slot hot-plug controller
`timescale 1ns/100ps
module test_downstream_slot_hotplug_control;
   import hpc_pkg::*;
   localparam logic [31:0] P_ILOCK = 32'h0000_0014;
   localparam logic [7:0] CFG = ADDR_HOTPLUG_CONFIG_CONTROL;
   localparam logic [7:0] CTL0 = 8'h14;
   localparam logic [7:0] STS0 = 8'h18;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic clk_en = 1'b1;
   logic ee_done = 1'b0;
   logic slow = 1'b0;
   logic exp_done, exp_init, exp_update, irq;
   logic [N_SLOTS-1:0] rst_out;
   hpc_avm_req_t avm = '0;
   hpc_avm_rsp_t rsp;
   hpc_ee_wr_t ee = '0;
   hpc_slot_in_vec_t sense = '0;
   hpc_slot_in_vec_t slot_in;
   hpc_slot_out_vec_t slot_out;
   logic [31:0] rd;
   int bad_count = 0;
   int n_compared = 0;
   int cyc = 0;
   hpc_slot_ctrl #(.P_ILOCK_CYCLES(P_ILOCK)) dut (.i_sys_clk(clk), .i_rstn(rstn),
      .i_clk_en(clk_en), .i_avm(avm), .o_avm(rsp), .i_ee_wr(ee), .i_ee_done(ee_done),
      .i_slot_in(slot_in), .o_slot_out(slot_out), .o_exp_init(exp_init),
      .o_exp_update(exp_update), .i_exp_done(exp_done), .o_slot_reset_out(rst_out), .o_irq(irq));
   hpc_exp_model exp_model (.i_sys_clk(clk), .i_rstn(rstn), .i_update(exp_update),
      .o_done(exp_done), .o_slot_in(slot_in), .i_sense(sense), .i_slow(slow));
   always #2 clk = ~clk;
   task automatic stop_test;
      $display("Comparisons %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : stop_test
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         bad_count++;
         $display("CHECK FAILED timeout expected 0 seen %0d", cyc);
         stop_test();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // Held until waitrequest is sampled low at a rising edge
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      avm <= '{read: !wr, write: wr, address: a, byteenable: 4'hF, writedata: d};
      do @(posedge clk); while (rsp.waitrequest !== 1'b0);
      rd = rsp.readdata;
      avm.read <= 1'b0;
      avm.write <= 1'b0;
   endtask : bus
   task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
      input string nm);
      bus(1'b0, a, '0);
      chk(nm, e, rd & m);
   endtask : rdc
   task automatic eew(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      ee <= '{valid: 1'b1, address: a, data: d};
      @(posedge clk);
      ee.valid <= 1'b0;
   endtask : eew
   task automatic settle;
      repeat (12) @(posedge clk);
      @(negedge clk);
   endtask : settle
   task automatic pulse_len(output int n);
      n = 0;
      repeat (4) begin
         @(negedge clk);
         if (slot_out[0].interlock === 1'b1) break;
      end
      while (slot_out[0].interlock === 1'b1 && n < 60) begin
         n++;
         @(negedge clk);
      end
   endtask : pulse_len
   task automatic t_reset;
      settle();
      chk("outputs", '0, 32'({slot_out, rst_out, irq}));
      rdc(CFG, '1, CFG_RESET, "config");
      rdc(CTL0, '1, CTL_RESET, "control");
   endtask : t_reset
   task automatic t_ee;
      int n_init = 0;
      logic busy = 1'b0;
      eew(8'h10, 32'h0000_0044);
      eew(8'h20, 32'h0000_0040);
      eew(8'h30, 32'h0000_0040);
      eew(CTL0, 32'h0000_0FC0);
      @(posedge clk);
      ee_done <= 1'b1;
      repeat (8) begin
         @(negedge clk);
         if (exp_init === 1'b1) n_init++;
         busy = busy | exp_update | slot_out[0].interlock;
      end
      chk("init", 1, n_init);
      chk("no command", 0, busy);
      rdc(STS0, 32'h0000_0010, '0, "completed");
      bus(1'b1, 8'h10, '0);
      rdc(8'h10, '1, 32'h0000_0044, "caps");
      rdc(8'h40, '1, '0, "no port");
   endtask : t_ee
   task automatic t_pulse;
      int n;
      logic ilock_seen;
      slow <= 1'b1;
      bus(1'b1, CTL0, 32'h0000_0FC0);
      fork
         pulse_len(n);
         begin
            repeat (6) @(posedge clk);
            bus(1'b0, STS0, '0);
            ilock_seen = rd[STS_INTERLOCK_STATE];
         end
      join
      chk("pulse", P_ILOCK, n);
      chk("state high", 1, ilock_seen);
      rdc(STS0, 32'h0000_0090, 32'h0000_0010, "state low");
      chk("irq masked", 0, irq);
      bus(1'b1, ADDR_IRQ_MASK, 32'h0000_0001);
      @(negedge clk);
      chk("irq", 1, irq);
      bus(1'b1, STS0, 32'h0000_0010);
      bus(1'b1, ADDR_IRQ_STATUS, 32'h0000_0001);
      @(negedge clk);
      chk("irq cleared", 0, irq);
   endtask : t_pulse
   task automatic t_toggle;
      bus(1'b1, CFG, 32'h0001_0000);
      bus(1'b1, CTL0, 32'h0000_0FC0);
      repeat (40) @(posedge clk);
      @(negedge clk);
      chk("toggle on", 1, slot_out[0].interlock);
      bus(1'b1, CTL0, 32'h0000_0FC0);
      settle();
      chk("toggle off", 0, slot_out[0].interlock);
      bus(1'b1, CFG, '0);
   endtask : t_toggle
   task automatic t_polarity;
      bus(1'b1, CTL0, 32'h0000_0740);
      settle();
      chk("attn on", 1, slot_out[0].attn_indicator);
      chk("gpio reset", 3'h7, rst_out);
      bus(1'b1, CFG, 32'h0000_02E2);
      settle();
      for (int k = 0; k < N_SLOTS; k++) begin
         chk("attn inv", k != 0, slot_out[k].attn_indicator);
         chk("pwr inv", 2'h3, {slot_out[k].power_indicator, slot_out[k].power_enable});
      end
      chk("gpio inv", '0, rst_out);
      rdc(STS0, 32'h0000_0040, 32'h0000_0040, "presence inv");
      @(posedge clk);
      sense[0].presence <= 1'b1;
      settle();
      rdc(STS0, 32'h0000_0048, 32'h0000_0008, "presence");
      bus(1'b1, CFG, '0);
   endtask : t_polarity
   task automatic t_latch;
      @(posedge clk);
      sense[0].power_good <= 1'b1;
      bus(1'b1, CFG, 32'h0004_0000);
      bus(1'b1, CTL0, 32'h0000_03C0);
      settle();
      chk("power on", 1, slot_out[0].power_enable);
      @(posedge clk);
      sense[0].latch_sensor <= 1'b1;
      settle();
      chk("auto off", 0, slot_out[0].power_enable);
      rdc(STS0, 32'h0000_00A0, 32'h0000_0020, "latch open");
      bus(1'b1, CFG, 32'h0006_0000);
      rdc(STS0, 32'h0000_00A0, 32'h0000_0080, "latch as state");
      @(posedge clk);
      sense[0].latch_sensor <= 1'b0;
      settle();
      rdc(STS0, 32'h0000_00A0, '0, "latch closed");
   endtask : t_latch
   initial begin
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      t_reset();
      t_ee();
      t_pulse();
      t_toggle();
      t_polarity();
      t_latch();
      stop_test();
   end
endmodule : test_downstream_slot_hotplug_control
